// file: core/usbps_pkg.sv
// Package: register map, field positions, reset values and bus states
// for the USB / PS/2 control and status register bank.
// Assumes a 32-bit AHB-Lite slave, one aligned word per register.
package usbps_pkg;

    // ****************************************************************
    // Register indexes (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_LINK     = 8'h1a; // link_status_control
    localparam logic [7:0] IDX_EPSEL    = 8'h1b; // endpoint_flags_bus_select
    localparam logic [7:0] IDX_CLKCTL   = 8'h1c; // system_clock_control
    localparam logic [7:0] IDX_TABLE_HIGH_POINTER     = 8'h1f; // table_high_pointer
    localparam logic [7:0] IDX_IRQ_STAT = 8'h20; // interrupt status, write one to clear
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21; // interrupt mask, one enables

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned LINK_DAT_IN  = 4;
    localparam int unsigned LINK_CLK_IN  = 5;
    localparam int unsigned LINK_DAT_OUT = 6;
    localparam int unsigned LINK_CLK_OUT = 7;
    localparam int unsigned EP_NUM       = 4;  // endpoint flags in bits 3..0
    localparam int unsigned SEL_KBD      = 4;
    localparam int unsigned SEL_SERIAL   = 5;
    localparam int unsigned IND_SERIAL   = 7;
    localparam int unsigned CLK_BUS_EN   = 3;
    localparam int unsigned CLK_DEEP     = 4;
    localparam int unsigned CLK_OSC      = 6;
    localparam int unsigned IND_KBD      = 7;
    localparam int unsigned TABLE_HIGH_POINTER_W       = 5;
    localparam int unsigned IRQ_W        = 5;  // bits 3..0 endpoints, bit 4 clock fall
    localparam int unsigned IRQ_CLKFALL  = 4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic        LINK_OUT_RST = 1'b1;
    localparam logic [4:0]  IRQ_MASK_RST = 5'h00;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

    // ****************************************************************
    // Bus slave phase
    // ****************************************************************
    typedef enum logic {
        BUS_IDLE,
        BUS_DATA
    } usbps_bus_t;

endpackage

// file: core/usbps_sync_if.sv
// Interface: raw shared line levels into the synchroniser, settled out.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
`default_nettype none
interface usbps_sync_if;
    logic [1:0] raw;    // bit 0 data line, bit 1 clock line
    logic [1:0] synced;

    modport top  (output raw, input synced);
    modport sync (input raw, output synced);
endinterface
`default_nettype wire

// file: core/usbps_sync.sv
// Two-stage synchroniser for the shared line levels.
// Assumes raw levels come from pins, asynchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module usbps_sync (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    usbps_sync_if.sync  lines
);
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
    } usbps_sync_t;

    usbps_sync_t s_q;
    usbps_sync_t s_d;

    // First stage feeds only the second
    always_comb begin
        s_d        = s_q;
        s_d.meta   = lines.raw;
        s_d.stable = s_q.meta;
    end

    // Idle lines float high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{meta: 2'h3, stable: 2'h3};
        end else begin
            s_q <= s_d;
        end
    end

    assign lines.synced = s_q.stable;
endmodule
`default_nettype wire

// file: core/usbps_regs.sv
// Control and status register bank of the USB / PS/2 line interface.
// Assumes an AHB-Lite master on hclk, a USB engine on hclk that pulses
// ep_access and drives eng_*, and shared lines arriving from pins.
//
// Function
// - Write-only line drive bits reset high
// - Status bits 4,5 show line levels in keyboard mode only, each ANDed with its drive bit, else read 0
// - Endpoint access sets flag, raises interrupt
// - No new event until flag cleared
// - Bit 4 selects keyboard bus, resets 0
// - Bit 5 selects serial bus, resets 0
// - Select pair decides who drives lines
// - Serial mode indicator bit, resets 0
// - Clock control bit 3 gates bus clock
// - Deep suspend refused in serial mode
// - Bit 6 picks 6 or 12 MHz
// - Keyboard mode indicator bit, resets 0
// - Table pointer holds address bits 12..8
`timescale 1ns/1ps
`default_nettype none
module usbps_regs (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [3:0]  ep_access,
    input  wire logic        cpu_int_enable,
    input  wire logic        stack_full,
    input  wire logic        line_clk_in,
    output logic             line_clk_out,
    output logic             line_clk_oe,
    input  wire logic        line_dat_in,
    output logic             line_dat_out,
    output logic             line_dat_oe,
    input  wire logic        eng_clk_out,
    input  wire logic        eng_clk_oe,
    input  wire logic        eng_dat_out,
    input  wire logic        eng_dat_oe,
    output logic             usb_int,
    output logic             irq,
    output logic             bus_clock_enable,
    output logic             deep_suspend,
    output logic             low_voltage_reset_en,
    output logic             oscillator_rate_select,
    output logic [4:0]       table_page
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        usbps_pkg::usbps_bus_t bus;
        logic [7:0]  idx;
        logic        wr;
        logic        hready;
        logic [31:0] hrdata;
        logic        dat_out;
        logic        clk_out;
        logic [3:0]  ep_flag;
        logic        kbd_sel;
        logic        ser_sel;
        logic        ser_ind;
        logic        clk_en;
        logic        deep_susp;
        logic        lvr_en;
        logic        osc_sel;
        logic        kbd_ind;
        logic [4:0]  table_high_pointer;
        logic [4:0]  irq_stat;
        logic [4:0]  irq_mask;
        logic        irq;
        logic        usb_int;
        logic        clk_prev;
        logic        pin_clk_out;
        logic        pin_clk_oe;
        logic        pin_dat_out;
        logic        pin_dat_oe;
    } usbps_state_t;

    usbps_state_t s_q;
    usbps_state_t s_d;
    usbps_sync_if sl ();

    logic        take;
    logic        wr_now;
    logic [3:0]  ep_clear;
    logic [3:0]  ep_new;
    logic        kbd_mode;
    logic        ser_mode;
    logic        clk_fall;
    logic [4:0]  irq_event;
    logic [7:0]  rd_byte;

    // Register index from a byte address
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        return addr[9:2];
    endfunction

    // True when a data-phase write hits the given register
    function automatic logic wr_hit(input logic w, input logic [7:0] i,
                                    input logic [7:0] want);
        return w && (i == want);
    endfunction

    // ****************************************************************
    // Line synchroniser
    // ****************************************************************
    assign sl.raw = {line_clk_in, line_dat_in};

    usbps_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .lines   (sl)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d      = s_q;
        take     = hsel && hready && htrans[1];
        wr_now   = (s_q.bus == usbps_pkg::BUS_DATA) && s_q.wr;
        ep_clear = 4'h0;
        rd_byte  = 8'h00;

        // Bus phase tracking, one wait state per transfer
        case (s_q.bus)
            usbps_pkg::BUS_IDLE: begin
                s_d.hready = 1'b1;
                if (take) begin
                    s_d.bus    = usbps_pkg::BUS_DATA;
                    s_d.idx    = reg_index(haddr);
                    s_d.wr     = hwrite;
                    s_d.hready = 1'b0;
                end
            end
            usbps_pkg::BUS_DATA: begin
                s_d.bus    = usbps_pkg::BUS_IDLE;
                s_d.hready = 1'b1;
            end
            default: begin
                s_d.bus    = usbps_pkg::BUS_IDLE;
                s_d.hready = 1'b1;
            end
        endcase

        // Register writes in the data phase
        if (wr_hit(wr_now, s_q.idx, usbps_pkg::IDX_LINK)) begin
            s_d.dat_out = hwdata[usbps_pkg::LINK_DAT_OUT];
            s_d.clk_out = hwdata[usbps_pkg::LINK_CLK_OUT];
        end
        if (wr_hit(wr_now, s_q.idx, usbps_pkg::IDX_EPSEL)) begin
            ep_clear    = ~hwdata[usbps_pkg::EP_NUM-1:0] & s_q.ep_flag;
            s_d.ep_flag = hwdata[usbps_pkg::EP_NUM-1:0];
            s_d.kbd_sel = hwdata[usbps_pkg::SEL_KBD];
            s_d.ser_sel = hwdata[usbps_pkg::SEL_SERIAL];
            s_d.ser_ind = hwdata[usbps_pkg::IND_SERIAL];
        end
        if (wr_hit(wr_now, s_q.idx, usbps_pkg::IDX_CLKCTL)) begin
            s_d.clk_en    = hwdata[usbps_pkg::CLK_BUS_EN];
            s_d.deep_susp = hwdata[usbps_pkg::CLK_DEEP];
            s_d.osc_sel   = hwdata[usbps_pkg::CLK_OSC];
            s_d.kbd_ind   = hwdata[usbps_pkg::IND_KBD];
        end
        if (wr_hit(wr_now, s_q.idx, usbps_pkg::IDX_TABLE_HIGH_POINTER)) begin
            s_d.table_high_pointer = hwdata[usbps_pkg::TABLE_HIGH_POINTER_W-1:0];
        end
        if (wr_hit(wr_now, s_q.idx, usbps_pkg::IDX_IRQ_MASK)) begin
            s_d.irq_mask = hwdata[usbps_pkg::IRQ_W-1:0];
        end
        if (wr_hit(wr_now, s_q.idx, usbps_pkg::IDX_IRQ_STAT)) begin
            s_d.irq_stat = s_q.irq_stat & ~hwdata[usbps_pkg::IRQ_W-1:0];
        end

        // Mode from the select pair as it will stand
        kbd_mode = s_d.kbd_sel && !s_d.ser_sel;
        ser_mode = !s_d.kbd_sel && s_d.ser_sel;

        // Deep suspend never stands in serial mode
        if (ser_mode) begin
            s_d.deep_susp = 1'b0;
        end
        // Low-voltage reset only while deep suspend is off
        s_d.lvr_en = !s_d.deep_susp;

        // Endpoint events: taken only while the flag is clear or being cleared
        ep_new    = ep_access & (~s_q.ep_flag | ep_clear);
        s_d.ep_flag = s_d.ep_flag | ep_new;

        // Falling edge of the settled clock line in keyboard mode
        s_d.clk_prev = sl.synced[1];
        clk_fall     = s_q.clk_prev && !sl.synced[1] && kbd_mode;

        // Sticky status, set wins over a clearing write
        irq_event    = {clk_fall, ep_new};
        s_d.irq_stat = s_d.irq_stat | irq_event;
        s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

        // Interrupt towards the core while any endpoint waits, cpu_int_enable is high and stack_full is low
        s_d.usb_int = (|s_d.ep_flag) && cpu_int_enable && !stack_full;

        // Line drivers by mode
        if (kbd_mode) begin
            s_d.pin_clk_out = 1'b0;
            s_d.pin_clk_oe  = !s_d.clk_out;
            s_d.pin_dat_out = 1'b0;
            s_d.pin_dat_oe  = !s_d.dat_out;
        end else if (ser_mode) begin
            s_d.pin_clk_out = eng_clk_out;
            s_d.pin_clk_oe  = eng_clk_oe;
            s_d.pin_dat_out = eng_dat_out;
            s_d.pin_dat_oe  = eng_dat_oe;
        end else begin
            s_d.pin_clk_out = 1'b0;
            s_d.pin_clk_oe  = 1'b0;
            s_d.pin_dat_out = 1'b0;
            s_d.pin_dat_oe  = 1'b0;
        end

        // Read data, loaded at the end of the wait state
        case (s_q.idx)
            usbps_pkg::IDX_LINK: begin
                rd_byte[usbps_pkg::LINK_DAT_IN] = s_q.kbd_sel && !s_q.ser_sel
                                                  && sl.synced[0] && s_q.dat_out;
                rd_byte[usbps_pkg::LINK_CLK_IN] = s_q.kbd_sel && !s_q.ser_sel
                                                  && sl.synced[1] && s_q.clk_out;
            end
            usbps_pkg::IDX_EPSEL: begin
                rd_byte[usbps_pkg::EP_NUM-1:0]  = s_q.ep_flag;
                rd_byte[usbps_pkg::SEL_KBD]     = s_q.kbd_sel;
                rd_byte[usbps_pkg::SEL_SERIAL]  = s_q.ser_sel;
                rd_byte[usbps_pkg::IND_SERIAL]  = s_q.ser_ind;
            end
            usbps_pkg::IDX_CLKCTL: begin
                rd_byte[usbps_pkg::CLK_BUS_EN] = s_q.clk_en;
                rd_byte[usbps_pkg::CLK_DEEP]   = s_q.deep_susp;
                rd_byte[usbps_pkg::CLK_OSC]    = s_q.osc_sel;
                rd_byte[usbps_pkg::IND_KBD]    = s_q.kbd_ind;
            end
            usbps_pkg::IDX_TABLE_HIGH_POINTER: begin
                rd_byte[usbps_pkg::TABLE_HIGH_POINTER_W-1:0] = s_q.table_high_pointer;
            end
            usbps_pkg::IDX_IRQ_STAT: begin
                rd_byte[usbps_pkg::IRQ_W-1:0] = s_q.irq_stat;
            end
            usbps_pkg::IDX_IRQ_MASK: begin
                rd_byte[usbps_pkg::IRQ_W-1:0] = s_q.irq_mask;
            end
            default: begin
                rd_byte = 8'h00; // Unmapped reads as zero
            end
        endcase
        if (s_q.bus == usbps_pkg::BUS_DATA && !s_q.wr) begin
            s_d.hrdata = {24'h00_0000, rd_byte};
        end else begin
            s_d.hrdata = usbps_pkg::RDATA_ZERO;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q             <= '0;
            s_q.bus         <= usbps_pkg::BUS_IDLE;
            s_q.hready      <= 1'b1;
            s_q.dat_out     <= usbps_pkg::LINK_OUT_RST;
            s_q.clk_out     <= usbps_pkg::LINK_OUT_RST;
            s_q.irq_mask    <= usbps_pkg::IRQ_MASK_RST;
            s_q.clk_prev    <= 1'b1;
            s_q.lvr_en      <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs, all from flops except hresp, tied low
    // ****************************************************************
    assign hrdata                 = s_q.hrdata;
    assign hreadyout              = s_q.hready;
    assign hresp                  = 1'b0; // Always OKAY
    assign usb_int                = s_q.usb_int;
    assign irq                    = s_q.irq;
    assign bus_clock_enable       = s_q.clk_en;
    assign deep_suspend           = s_q.deep_susp;
    assign low_voltage_reset_en   = s_q.lvr_en;
    assign oscillator_rate_select = s_q.osc_sel;
    assign table_page             = s_q.table_high_pointer;
    assign line_clk_out           = s_q.pin_clk_out;
    assign line_clk_oe            = s_q.pin_clk_oe;
    assign line_dat_out           = s_q.pin_dat_out;
    assign line_dat_oe            = s_q.pin_dat_oe;

    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:10], haddr[1:0], hwdata[31:8]};
endmodule
`default_nettype wire

// file: core/HANDOVER_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: testbench/usbps_regs_props.sv
// Checker: port timing of the register bank, bound from the bench.
// Assumes one clock, hclk, and the async active-low reset hresetn.
`timescale 1ns/1ps
`default_nettype none
module usbps_regs_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic [3:0]  ep_access,
    input wire logic        cpu_int_enable,
    input wire logic        stack_full,
    input wire logic        line_clk_out,
    input wire logic        line_clk_oe,
    input wire logic        line_dat_out,
    input wire logic        line_dat_oe,
    input wire logic        eng_clk_oe,
    input wire logic        eng_dat_out,
    input wire logic        eng_dat_oe,
    input wire logic        usb_int,
    input wire logic        bus_clock_enable,
    input wire logic        deep_suspend,
    input wire logic        low_voltage_reset_en,
    input wire logic        oscillator_rate_select,
    input wire logic [4:0]  table_page
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence bus_take; hsel && hready && htrans[1]; endsequence
    sequence one_wait; !hreadyout ##1 hreadyout; endsequence
    ready_wait_a: assert property (bus_take |=> one_wait)
        else $error("bus wait state is not exactly one cycle");
    rdata_idle_a: assert property (hrdata != 32'h0 |-> hreadyout && !$past(hreadyout))
        else $error("read data outside its data phase");
    usb_raise_a: assert property (
        (|ep_access) && cpu_int_enable && !stack_full ##1 cpu_int_enable && !stack_full
        |-> ##[0:1] usb_int) else $error("endpoint event raised no interrupt");
    usb_quiet_a: assert property ((!cpu_int_enable || stack_full) [*3] |-> !usb_int)
        else $error("interrupt while disabled or stack full");
    lvr_follow_a: assert property ($stable(deep_suspend) |-> low_voltage_reset_en != deep_suspend)
        else $error("low-voltage reset enable does not follow deep suspend");
    dat_high_a: assert property (
        line_dat_oe && line_dat_out |-> $past(eng_dat_oe) && $past(eng_dat_out))
        else $error("data line driven high outside serial mode");
    clk_low_a: assert property (line_clk_oe && !$past(eng_clk_oe) |-> !line_clk_out)
        else $error("clock line driven high in keyboard mode");
    cfg_write_a: assert property ($changed(table_page) || $changed(bus_clock_enable)
        || $changed(oscillator_rate_select) |-> !$past(hreadyout))
        else $error("configuration output changed without a write");
endmodule
`default_nettype wire

// file: testbench/usbps_host_model.sv
// Model of the keyboard-bus host on the two shared lines.
// Assumes a pull-up on each line; the host only ever pulls low.
`timescale 1ns/1ps
`default_nettype none
module usbps_host_model (
    input  wire logic clk_oe,
    input  wire logic clk_out,
    input  wire logic dat_oe,
    input  wire logic dat_out,
    input  wire logic dat_low,
    output logic      clk_wire,
    output logic      dat_wire
);
    logic clk_low = 1'b0;
    // Wired-AND of device drive, host pull and pull-up
    assign clk_wire = (clk_oe ? clk_out : 1'b1) & !clk_low;
    assign dat_wire = (dat_oe ? dat_out : 1'b1) & !dat_low;
    // Clock frame at 400 ns, line released between frames
    task automatic clock_frame(input int n);
        for (int i = 0; i < n; i++) begin
            #200 clk_low = 1'b1;
            #200 clk_low = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: testbench/usbps_regs_test.sv
// Testbench: register traffic over AHB-Lite against expected values.
// Assumes the host model on the lines and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module usbps_regs_test;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, dat_low;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  ep_access;
    logic        cpu_int_enable, stack_full, clk_wire, dat_wire, usb_int, irq;
    logic        line_clk_out, line_clk_oe, line_dat_out, line_dat_oe;
    logic        eng_clk_out, eng_clk_oe, eng_dat_out, eng_dat_oe;
    logic        bus_clock_enable, deep_suspend, low_voltage_reset_en, osc_sel;
    logic [4:0]  table_page;
    int          n_fail, total_checks;
    // Design and host
    usbps_regs usbps_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ep_access(ep_access),
        .cpu_int_enable(cpu_int_enable), .stack_full(stack_full), .line_clk_in(clk_wire),
        .line_clk_out(line_clk_out), .line_clk_oe(line_clk_oe), .line_dat_in(dat_wire),
        .line_dat_out(line_dat_out), .line_dat_oe(line_dat_oe), .eng_clk_out(eng_clk_out),
        .eng_clk_oe(eng_clk_oe), .eng_dat_out(eng_dat_out), .eng_dat_oe(eng_dat_oe),
        .usb_int(usb_int), .irq(irq), .bus_clock_enable(bus_clock_enable),
        .deep_suspend(deep_suspend), .low_voltage_reset_en(low_voltage_reset_en),
        .oscillator_rate_select(osc_sel), .table_page(table_page));
    usbps_host_model usbps_host_model_inst (.clk_oe(line_clk_oe), .clk_out(line_clk_out),
        .dat_oe(line_dat_oe), .dat_out(line_dat_out), .dat_low(dat_low),
        .clk_wire(clk_wire), .dat_wire(dat_wire));
    // ****************************************************************
    // Bus tasks and compares
    // ****************************************************************
    always #25 hclk = !hclk;
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t word got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                        output logic [31:0] rd);
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk_bit(hresp, 1'b0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        xfer(idx, 1'b1, wd, rd);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        xfer(idx, 1'b0, 8'h00, rd);
        chk_word(rd, {24'h0, exp});
    endtask
    task automatic settle();
        repeat (4) @(posedge hclk);
    endtask
    task automatic pulse(input int n);
        ep_access <= 4'h1 << n;
        @(posedge hclk);
        ep_access <= 4'h0;
        @(posedge hclk);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        static logic [7:0] idx [7] = '{8'h1a, 8'h1b, 8'h1c, 8'h1f, 8'h20, 8'h21, 8'h1d};
        {hclk, hresetn, hsel, hwrite, dat_low, cpu_int_enable, stack_full} = '0;
        {eng_clk_out, eng_clk_oe, eng_dat_out, eng_dat_oe, ep_access} = '0;
        {haddr, hwdata, htrans, n_fail, total_checks} = '0;
        hsize = 3'b010;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_bit(low_voltage_reset_en, 1'b1);
        wr(8'h1d, 8'hff);
        foreach (idx[i]) rd_chk(idx[i], 8'h00);
        wr(usbps_pkg::IDX_CLKCTL, 8'hc8);
        rd_chk(usbps_pkg::IDX_CLKCTL, 8'hc8);
        chk_bit(bus_clock_enable, 1'b1);
        chk_bit(osc_sel, 1'b1);
        wr(usbps_pkg::IDX_CLKCTL, 8'h00);
        chk_bit(osc_sel, 1'b0);
        wr(usbps_pkg::IDX_TABLE_HIGH_POINTER, 8'hff);
        rd_chk(usbps_pkg::IDX_TABLE_HIGH_POINTER, 8'h1f);
        chk_word({27'h0, table_page}, 32'h1f);
        // Keyboard mode: released lines, sensing, open-drain drive
        wr(usbps_pkg::IDX_EPSEL, 8'h10);
        rd_chk(usbps_pkg::IDX_EPSEL, 8'h10);
        settle();
        chk_bit(line_dat_oe, 1'b0);
        rd_chk(usbps_pkg::IDX_LINK, 8'h30);
        dat_low <= 1'b1;
        settle();
        rd_chk(usbps_pkg::IDX_LINK, 8'h20);
        dat_low <= 1'b0;
        wr(usbps_pkg::IDX_LINK, 8'h00);
        settle();
        chk_bit(line_dat_oe, 1'b1);
        chk_bit(line_dat_out, 1'b0);
        chk_bit(line_clk_oe, 1'b1);
        chk_bit(line_clk_out, 1'b0);
        rd_chk(usbps_pkg::IDX_LINK, 8'h00);
        wr(usbps_pkg::IDX_LINK, 8'hc0);
        wr(usbps_pkg::IDX_IRQ_STAT, 8'h10);
        usbps_host_model_inst.clock_frame(2);
        @(posedge hclk);
        settle();
        rd_chk(usbps_pkg::IDX_IRQ_STAT, 8'h10);
        chk_bit(irq, 1'b0);
        wr(usbps_pkg::IDX_IRQ_MASK, 8'h10);
        settle();
        chk_bit(irq, 1'b1);
        wr(usbps_pkg::IDX_IRQ_STAT, 8'h10);
        settle();
        chk_bit(irq, 1'b0);
        // Deep suspend allowed in keyboard mode, refused in serial mode
        wr(usbps_pkg::IDX_CLKCTL, 8'h10);
        settle();
        chk_bit(deep_suspend, 1'b1);
        chk_bit(low_voltage_reset_en, 1'b0);
        {eng_dat_oe, eng_dat_out, eng_clk_oe} <= 3'b111;
        wr(usbps_pkg::IDX_EPSEL, 8'h20);
        settle();
        chk_bit(deep_suspend, 1'b0);
        wr(usbps_pkg::IDX_CLKCTL, 8'h10);
        rd_chk(usbps_pkg::IDX_CLKCTL, 8'h00);
        chk_bit(line_dat_out, 1'b1);
        chk_bit(line_clk_oe, 1'b1);
        wr(usbps_pkg::IDX_EPSEL, 8'ha0);
        rd_chk(usbps_pkg::IDX_EPSEL, 8'ha0);
        // Endpoint flags, interrupt, hold-off until cleared
        cpu_int_enable <= 1'b1;
        wr(usbps_pkg::IDX_IRQ_MASK, 8'h0f);
        for (int n = 0; n < 4; n++) begin
            pulse(n);
            settle();
            chk_bit(usb_int, 1'b1);
            chk_bit(irq, 1'b1);
            rd_chk(usbps_pkg::IDX_EPSEL, 8'ha0 | (8'h01 << n));
            wr(usbps_pkg::IDX_EPSEL, 8'ha0);
            wr(usbps_pkg::IDX_IRQ_STAT, 8'h01 << n);
        end
        pulse(0);
        wr(usbps_pkg::IDX_IRQ_STAT, 8'h01);
        pulse(0);
        rd_chk(usbps_pkg::IDX_IRQ_STAT, 8'h00);
        stack_full <= 1'b1;
        settle();
        chk_bit(usb_int, 1'b0);
        stack_full <= 1'b0;
        wr(usbps_pkg::IDX_EPSEL, 8'ha0);
        pulse(0);
        rd_chk(usbps_pkg::IDX_IRQ_STAT, 8'h01);
        wrap_up();
    end
    // Watchdog against a hung handshake
    initial begin
        #2000000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule
bind usbps_regs usbps_regs_props usbps_regs_props_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .ep_access(ep_access), .cpu_int_enable(cpu_int_enable), .stack_full(stack_full),
    .line_clk_out(line_clk_out), .line_clk_oe(line_clk_oe), .line_dat_out(line_dat_out),
    .line_dat_oe(line_dat_oe), .eng_clk_oe(eng_clk_oe), .eng_dat_out(eng_dat_out),
    .eng_dat_oe(eng_dat_oe), .usb_int(usb_int), .bus_clock_enable(bus_clock_enable),
    .deep_suspend(deep_suspend), .low_voltage_reset_en(low_voltage_reset_en),
    .oscillator_rate_select(oscillator_rate_select), .table_page(table_page));
`default_nettype wire
